// >>> core/chs_host_link.sv
// Two-wire bus target, status/control register and indicator outputs.
// Assumes charger state and fault levels come from logic on clk_sys_i.
`timescale 1ns/1ps
// How it works
// - Indicator pulled low while charging if the indicator enable bit is 1.
// - Indicator released to high impedance in every other normal condition.
// - Each new fault or status event gives one 128 us low pulse, then release; none while a pulse runs.
// - Supply, timer, watchdog, sleep, temperature, battery, thermal events trigger pulse.
// - Event pulses ignore the enable bit; it gates only the charging level.
// - Alert output behaves exactly like the charge indicator.
// - Unmanaged mode with battery above threshold forces high impedance mode.
// - Managed mode ignores the good battery check.
// - Target only; standard and fast transfers share one protocol.
// - Answers only its fixed 7-bit address; other frames are ignored.
// - Start is SDA falling with SCL high; stop is SDA rising with SCL high.
// - Matching address acknowledged by holding SDA low over ninth clock high.
// - Bytes are eight bits plus acknowledge from the receiver, any count.
// - After stop the bus is free; wait for start and matching address.
// - Reads of unimplemented offsets return FFh.
// - Writing 1 to bit 7 kicks the watchdog; bit reads back 0.
// - Bits 6..4 report the operating phase code.
// - Bit 3 is read/write input priority, reset 0, 1 means USB first.
// - Bits 2..0 report the error code.
// - Error code kept first-come, cleared on read once its condition is gone.
// - Priority change with both supplies present forces high impedance and restart.
module chs_host_link
  import chs_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
)(
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // Two-wire bus pins
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  // Charger state from the charging core
  input  wire logic        charging_i,
  input  wire logic        ind_enable_i,
  input  wire logic [2:0]  phase_i,
  input  wire logic [6:0]  fault_cond_i,
  input  wire logic        supply_event_i,
  input  wire logic        sleep_event_i,
  input  wire logic        managed_i,
  input  wire logic        batt_above_good_i,
  input  wire logic        both_supplies_i,
  // Indicator and alert open-drain outputs
  output logic             stat_o,
  output logic             stat_oe_n_o,
  output logic             alert_o,
  output logic             alert_oe_n_o,
  // Controls to the charging core
  output logic             watchdog_kick_o,
  output logic             supply_sel_o,
  output logic             hiz_o,
  output logic             restart_o
);
  chs_line_if scl_l ();
  chs_line_if sda_l ();

  chs_state_t              state_ff;
  logic       [2:0]        bit_ff;
  logic       [7:0]        shift_ff;
  logic                    rw_ff;
  logic                    first_ff;
  logic       [7:0]        ptr_ff;
  logic                    drive_low_ff;
  logic                    sel_ff;
  logic       [2:0]        err_ff;
  logic       [2:0]        nxt_err;
  logic       [6:0]        cond_q_ff;
  logic [PULSE_CNT_W-1:0]  pulse_ff;
  logic                    kick_ff;
  logic                    restart_ff;
  logic                    hiz_ff;
  logic                    ind_low_ff;
  logic                    start_det;
  logic                    stop_det;
  logic                    wr_strobe;
  logic                    rd_load;
  logic                    event_any;
  logic       [7:0]        reg_rd;

  localparam logic [PULSE_CNT_W-1:0] PULSE_LOAD = PULSE_CNT_W'(PULSE_LEN - 1);

  chs_pin_filter u_scl (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .pin_i     (scl_i),
    .line      (scl_l)
  );

  chs_pin_filter u_sda (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .pin_i     (sda_i),
    .line      (sda_l)
  );

  // Bus conditions; SDA moving while SCL high is start or stop
  assign start_det = sda_l.fall && scl_l.level;
  assign stop_det  = sda_l.rise && scl_l.level;

  // Register read view; kick bit always reads 0
  assign reg_rd = (ptr_ff == REG_STATUS_CTRL) ?
                  {1'b0, phase_i, sel_ff, err_ff} :
                  UNMAPPED_READ;

  // Byte-complete strobes for the register side
  assign wr_strobe = (state_ff == ST_WR) && scl_l.rise && (bit_ff == BIT_LAST) && !first_ff;
  assign rd_load   = scl_l.fall && (((state_ff == ST_ADDR_AK) && rw_ff && drive_low_ff) ||
                                    ((state_ff == ST_RD_AK) && !shift_ff[0]));

  // Serial engine: sample on SCL rise, change SDA on SCL fall
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff     <= ST_IDLE;
      bit_ff       <= 3'h0;
      shift_ff     <= 8'h00;
      rw_ff        <= 1'b0;
      first_ff     <= 1'b0;
      ptr_ff       <= REG_STATUS_CTRL;
      drive_low_ff <= 1'b0;
    end else if (stop_det) begin
      state_ff     <= ST_IDLE;
      drive_low_ff <= 1'b0;
    end else if (start_det) begin
      state_ff     <= ST_ADDR;
      bit_ff       <= 3'h0;
      drive_low_ff <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          drive_low_ff <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_l.rise) begin
            shift_ff <= {shift_ff[6:0], sda_l.level};
            bit_ff   <= bit_ff + 3'h1;
            if (bit_ff == BIT_LAST) begin
              rw_ff    <= sda_l.level;
              first_ff <= 1'b1;
              // Foreign address: sit idle until the next start
              state_ff <= (shift_ff[6:0] == DEV_ADDR) ? ST_ADDR_AK : ST_IDLE;
            end
          end
        end
        ST_ADDR_AK, ST_WR_AK: begin
          if (scl_l.fall) begin
            if (!drive_low_ff) begin
              drive_low_ff <= 1'b1;
            end else if (rw_ff) begin
              shift_ff     <= {reg_rd[6:0], 1'b0};
              drive_low_ff <= !reg_rd[7];
              bit_ff       <= 3'h0;
              state_ff     <= ST_RD;
            end else begin
              drive_low_ff <= 1'b0;
              bit_ff       <= 3'h0;
              state_ff     <= ST_WR;
            end
          end
        end
        ST_WR: begin
          if (scl_l.rise) begin
            shift_ff <= {shift_ff[6:0], sda_l.level};
            bit_ff   <= bit_ff + 3'h1;
            if (bit_ff == BIT_LAST) begin
              if (first_ff) begin
                ptr_ff <= {shift_ff[6:0], sda_l.level};
              end
              first_ff <= 1'b0;
              state_ff <= ST_WR_AK;
            end
          end
        end
        ST_RD: begin
          if (scl_l.fall) begin
            if (bit_ff == BIT_LAST) begin
              drive_low_ff <= 1'b0;                         // Host acknowledges
              state_ff     <= ST_RD_AK;
            end else begin
              drive_low_ff <= !shift_ff[7];
              shift_ff     <= {shift_ff[6:0], 1'b0};
              bit_ff       <= bit_ff + 3'h1;
            end
          end
        end
        ST_RD_AK: begin
          // Host ack lands in shift_ff[0]; a nack ends our part of the frame
          if (scl_l.rise) begin
            shift_ff <= {7'h00, sda_l.level};
          end else if (scl_l.fall) begin
            if (shift_ff[0]) begin
              state_ff <= ST_IDLE;
            end else begin
              shift_ff     <= {reg_rd[6:0], 1'b0};
              drive_low_ff <= !reg_rd[7];
              bit_ff       <= 3'h0;
              state_ff     <= ST_RD;
            end
          end
        end
        default: begin
          state_ff     <= ST_IDLE;
          drive_low_ff <= 1'b0;
        end
      endcase
    end
  end

  // Open drain data pin: only ever pulls low
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sda_o      <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end else begin
      sda_o      <= 1'b0;
      sda_oe_n_o <= !drive_low_ff;
    end
  end

  // Priority bit, watchdog kick and supply restart
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sel_ff     <= SEL_RESET;
      kick_ff    <= 1'b0;
      restart_ff <= 1'b0;
    end else begin
      kick_ff    <= wr_strobe && (ptr_ff == REG_STATUS_CTRL) && shift_ff[KICK_BIT-1];
      restart_ff <= 1'b0;
      if (wr_strobe && (ptr_ff == REG_STATUS_CTRL)) begin
        sel_ff     <= shift_ff[SEL_BIT-1];
        restart_ff <= both_supplies_i && (shift_ff[SEL_BIT-1] != sel_ff);
      end
    end
  end

  // First active fault wins when several appear together
  function automatic logic [2:0] first_fault(input logic [6:0] cond);
    logic [2:0] code;
    code = ERR_NONE;
    for (int i = N_FAULTS - 1; i >= 0; i--) begin
      if (cond[i]) begin
        code = 3'(i + 1);
      end
    end
    return code;
  endfunction

  // Error code: hold until read with the condition gone; a live fault reloads
  always_comb begin
    nxt_err = err_ff;
    if (err_ff == ERR_NONE) begin
      nxt_err = first_fault(fault_cond_i);
    end else if (rd_load && (ptr_ff == REG_STATUS_CTRL) && !fault_cond_i[err_ff - 3'h1]) begin
      nxt_err = first_fault(fault_cond_i);                  // Set wins over clear
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      err_ff <= ERR_NONE;
    end else begin
      err_ff <= nxt_err;
    end
  end

  // Event detection: new fault level or supply/sleep strobe
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cond_q_ff <= 7'h00;
    end else begin
      cond_q_ff <= fault_cond_i;
    end
  end
  assign event_any = (|(fault_cond_i & ~cond_q_ff)) || supply_event_i || sleep_event_i;

  // Pulse timer; a running pulse is never retriggered
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_ff <= '0;
    end else if (pulse_ff != '0) begin
      pulse_ff <= pulse_ff - PULSE_CNT_W'(1);
    end else if (event_any) begin
      pulse_ff <= PULSE_LOAD;
    end
  end

  // Indicator level: pulse regardless of enable, charging only if enabled
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ind_low_ff <= 1'b0;
    end else begin
      ind_low_ff <= (event_any || (pulse_ff != '0)) ||
                    (charging_i && ind_enable_i);
    end
  end

  // Both open-drain outputs share one source so they cannot drift apart
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stat_o       <= 1'b0;
      stat_oe_n_o  <= 1'b1;
      alert_o      <= 1'b0;
      alert_oe_n_o <= 1'b1;
    end else begin
      stat_o       <= 1'b0;
      stat_oe_n_o  <= !ind_low_ff;
      alert_o      <= 1'b0;
      alert_oe_n_o <= !ind_low_ff;
    end
  end

  // High impedance request from the good battery check or a supply swap
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      hiz_ff <= 1'b0;
    end else begin
      hiz_ff <= (!managed_i && batt_above_good_i) ||
                restart_ff;
    end
  end

  assign watchdog_kick_o = kick_ff;
  assign supply_sel_o    = sel_ff;
  assign hiz_o           = hiz_ff;
  assign restart_o       = restart_ff;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  sequence s_event_idle;
    event_any && (pulse_ff == '0);
  endsequence

  sequence s_pulse_low;
    !stat_oe_n_o [*8];
  endsequence

  a_pulse_starts_low: assert property (s_event_idle |-> ##2 s_pulse_low)
    else $error("event pulse not driven low");
  a_alert_tracks_stat: assert property (alert_oe_n_o == stat_oe_n_o)
    else $error("alert differs from indicator");
  a_charge_level: assert property (charging_i && ind_enable_i |-> ##2 !stat_oe_n_o)
    else $error("charging level missing");
  a_idle_release: assert property (!charging_i && !event_any && pulse_ff == '0 && !ind_low_ff
                                   |-> ##1 stat_oe_n_o)
    else $error("indicator held without cause");
  a_no_retrigger: assert property (pulse_ff > PULSE_CNT_W'(1) |=> pulse_ff == $past(pulse_ff) - PULSE_CNT_W'(1))
    else $error("pulse timer retriggered");
  a_hiz_unmanaged: assert property (!managed_i && batt_above_good_i |=> hiz_o)
    else $error("good battery check ignored");
  a_hiz_managed: assert property (managed_i && !restart_ff |=> !hiz_o)
    else $error("managed mode inhibited");
  a_kick_pulse: assert property (watchdog_kick_o |=> !watchdog_kick_o)
    else $error("kick not one cycle");
  a_stop_idle: assert property (stop_det |=> state_ff == ST_IDLE && !drive_low_ff ##1 sda_oe_n_o)
    else $error("stop did not free bus");
  a_foreign_addr: assert property (state_ff == ST_ADDR && scl_l.rise && bit_ff == BIT_LAST
                                   && shift_ff[6:0] != DEV_ADDR && !start_det && !stop_det
                                   |=> state_ff == ST_IDLE)
    else $error("foreign address answered");
  a_restart_swap: assert property (restart_o |=> hiz_o)
    else $error("swap without high impedance");
endmodule : chs_host_link

// >>> core/chs_line_if.sv
// Carries one filtered bus line with its edge strobes between modules.
// Assumes both ends run on the system clock.
`timescale 1ns/1ps
interface chs_line_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface : chs_line_if

// >>> core/chs_pin_filter.sv
// Three-stage synchroniser and glitch filter for one bus pin.
// Assumes the pin is asynchronous to clk_sys_i and idles high.
`timescale 1ns/1ps
module chs_pin_filter
  import chs_pkg::*;
(
  // Clock and reset
  input  wire logic   clk_sys_i,
  input  wire logic   rst_i,
  // Raw pin and filtered result
  input  wire logic   pin_i,
  chs_line_if.src     line
);
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;
  logic rise_ff;
  logic fall_ff;

  // Synchroniser chain; s1 feeds only s2 to keep metastability contained
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Level moves only once two stages agree; edges are flagged in the same cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      lvl_ff  <= 1'b1;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      rise_ff <= (s2_ff == s3_ff) && s3_ff && !lvl_ff;
      fall_ff <= (s2_ff == s3_ff) && !s3_ff && lvl_ff;
      if (s2_ff == s3_ff) begin
        lvl_ff <= s3_ff;
      end
    end
  end

  assign line.level = lvl_ff;
  assign line.rise  = rise_ff;
  assign line.fall  = fall_ff;
endmodule : chs_pin_filter

// >>> core/chs_pkg.sv
// Constants, field layout and state codes for the charger host link block.
// Assumes a 100 MHz system clock; imported whole by the host link and pin filter modules.
package chs_pkg;
  // Clock and timing
  localparam int unsigned CLK_MHZ      = 100;
  localparam int unsigned PULSE_US     = 128;
  localparam int unsigned PULSE_CYCLES = PULSE_US * CLK_MHZ;
  localparam int unsigned PULSE_CNT_W  = 14;

  // Bus target identity and register map
  localparam logic [6:0] DEV_ADDR         = 7'h6b;
  localparam logic [7:0] REG_STATUS_CTRL  = 8'h00;
  localparam logic [7:0] UNMAPPED_READ    = 8'hff;

  // Field positions of the status and control register
  localparam int unsigned KICK_BIT  = 7;
  localparam int unsigned PHASE_LSB = 4;
  localparam int unsigned SEL_BIT   = 3;
  localparam int unsigned ERR_LSB   = 0;

  // Reset values and error codes
  localparam logic       SEL_RESET  = 1'b0;
  localparam logic [2:0] ERR_NONE   = 3'h0;
  localparam int unsigned N_FAULTS  = 7;
  localparam logic [2:0] BIT_LAST   = 3'h7;

  // Serial engine states, one-hot
  typedef enum logic [6:0] {
    ST_IDLE    = 7'h01,
    ST_ADDR    = 7'h02,
    ST_ADDR_AK = 7'h04,
    ST_WR      = 7'h08,
    ST_WR_AK   = 7'h10,
    ST_RD      = 7'h20,
    ST_RD_AK   = 7'h40
  } chs_state_t;
endpackage : chs_pkg

// >>> testbench/chs_host_link_test.sv
// Self-checking bench for the charger host link block.
// Assumes the host model is compiled before this file.
`timescale 1ns/1ps
module chs_host_link_test;
  import chs_pkg::*;
  localparam int unsigned PLEN = 20;
  // Clock, reset and charger-side inputs
  logic       clk_sys_i         = 1'b0;
  logic       rst_i             = 1'b1;
  logic       charging_i        = 1'b0;
  logic       ind_enable_i      = 1'b0;
  logic [2:0] phase_i           = 3'h0;
  logic [6:0] fault_cond_i      = 7'h00;
  logic       supply_event_i    = 1'b0;
  logic       sleep_event_i     = 1'b0;
  logic       managed_i         = 1'b1;
  logic       batt_above_good_i = 1'b0;
  logic       both_supplies_i   = 1'b0;
  // Design outputs and bus lines
  logic       sda_o, sda_oe_n_o, stat_o, stat_oe_n_o, alert_o, alert_oe_n_o;
  logic       watchdog_kick_o, supply_sel_o, hiz_o, restart_o, scl, sda_low;
  wire        sda_w = (sda_low === 1'b1 || sda_oe_n_o === 1'b0) ? 1'b0 : 1'b1;
  int         num_errors = 0, samples_checked = 0, kicks = 0, restarts = 0, hizs = 0, splits = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  chs_host_link #(.PULSE_LEN(PLEN)) dut_u (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .charging_i(charging_i), .ind_enable_i(ind_enable_i), .phase_i(phase_i),
    .fault_cond_i(fault_cond_i), .supply_event_i(supply_event_i), .sleep_event_i(sleep_event_i),
    .managed_i(managed_i), .batt_above_good_i(batt_above_good_i), .both_supplies_i(both_supplies_i),
    .stat_o(stat_o), .stat_oe_n_o(stat_oe_n_o), .alert_o(alert_o), .alert_oe_n_o(alert_oe_n_o),
    .watchdog_kick_o(watchdog_kick_o), .supply_sel_o(supply_sel_o), .hiz_o(hiz_o), .restart_o(restart_o));

  chs_host_model host_u (.clk_sys_i(clk_sys_i), .sda_i(sda_w), .scl_o(scl), .sda_low_o(sda_low));

  // Pulse counters, a watch on the two indicators staying alike and open-drain values staying 0
  always @(posedge clk_sys_i) begin
    if (watchdog_kick_o === 1'b1) kicks++;
    if (restart_o === 1'b1) restarts++;
    if (hiz_o === 1'b1) hizs++;
    if (stat_oe_n_o !== alert_oe_n_o) splits++;
    if ({sda_o, stat_o, alert_o} !== 3'b000) splits++;
  end

  task automatic stop_test();
    $display("mismatches %0d comparisons %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [7:0] exp_reg(input logic [2:0] p, input logic s, input logic [2:0] e);
    return {1'b0, p, s, e};
  endfunction

  // Sample settled outputs a number of cycles later
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic wr(input logic [7:0] b, input logic ack);
    logic a;
    host_u.write_byte(b, a);
    chk("ack", {7'h00, ~ack}, {7'h00, a});
  endtask

  // First data byte selects the offset
  task automatic reg_write(input logic [7:0] off, input logic [7:0] d);
    @(posedge clk_sys_i);
    host_u.start();
    wr({DEV_ADDR, 1'b0}, 1'b1);
    wr(off, 1'b1);
    wr(d, 1'b1);
    host_u.stop();
  endtask

  // Offset write, repeated start, two read bytes
  task automatic reg_read(input logic [7:0] off, output logic [7:0] v, output logic [7:0] v2);
    reg_write_off(off);
    host_u.start();
    wr({DEV_ADDR, 1'b1}, 1'b1);
    host_u.read_byte(1'b1, v);
    host_u.read_byte(1'b0, v2);
    host_u.stop();
  endtask

  task automatic reg_write_off(input logic [7:0] off);
    @(posedge clk_sys_i);
    host_u.start();
    wr({DEV_ADDR, 1'b0}, 1'b1);
    wr(off, 1'b1);
  endtask

  task automatic t_reset_phase();
    logic [7:0] v, v2;
    chk("supply_sel_o", 8'h00, {7'h00, supply_sel_o});
    chk("stat_oe_n_o", 8'h01, {7'h00, stat_oe_n_o});
    for (int p = 0; p < 8; p++) begin
      @(posedge clk_sys_i);
      phase_i <= 3'(p);
      reg_read(REG_STATUS_CTRL, v, v2);
      chk("phase", exp_reg(3'(p), SEL_RESET, ERR_NONE), v);
      chk("phase again", exp_reg(3'(p), SEL_RESET, ERR_NONE), v2);
    end
  endtask

  task automatic t_write();
    logic [7:0] v, v2;
    @(posedge clk_sys_i);
    both_supplies_i <= 1'b1;
    kicks = 0;
    restarts = 0;
    hizs = 0;
    reg_write(REG_STATUS_CTRL, 8'h88);
    chk("supply_sel_o", 8'h01, {7'h00, supply_sel_o});
    chk("restarts", 8'h01, 8'(restarts));
    chk("hiz pulses", 8'h01, 8'(hizs));
    reg_read(REG_STATUS_CTRL, v, v2);
    chk("kick reads 0", exp_reg(phase_i, 1'b1, ERR_NONE), v);
    reg_write(REG_STATUS_CTRL, 8'h08);
    reg_write(8'h05, 8'h00);
    chk("dropped write", 8'h01, {7'h00, supply_sel_o});
    reg_read(8'h05, v, v2);
    chk("unmapped", UNMAPPED_READ, v);
    chk("unmapped again", UNMAPPED_READ, v2);
    reg_write(REG_STATUS_CTRL, 8'h00);
    chk("restarts", 8'h02, 8'(restarts));
    chk("kicks", 8'h01, 8'(kicks));
    both_supplies_i <= 1'b0;
  endtask

  // Abandoned frame, then a foreign address that must stay unanswered
  task automatic t_addr();
    logic [7:0] v, v2;
    @(posedge clk_sys_i);
    host_u.start();
    wr({DEV_ADDR, 1'b0}, 1'b1);
    host_u.stop();
    host_u.start();
    wr({7'h6a, 1'b0}, 1'b0);
    wr(8'h00, 1'b0);
    host_u.stop();
    reg_read(REG_STATUS_CTRL, v, v2);
    chk("after stop", exp_reg(phase_i, 1'b0, ERR_NONE), v);
  endtask

  task automatic t_hiz();
    @(posedge clk_sys_i);
    managed_i <= 1'b0;
    batt_above_good_i <= 1'b1;
    cyc(3);
    chk("hiz unmanaged", 8'h01, {7'h00, hiz_o});
    @(posedge clk_sys_i);
    managed_i <= 1'b1;
    cyc(3);
    chk("hiz managed", 8'h00, {7'h00, hiz_o});
    @(posedge clk_sys_i);
    batt_above_good_i <= 1'b0;
  endtask

  // Event k: 0 supply, 1 sleep, 2.. fault bits; a sleep event lands mid-pulse
  task automatic pulse_chk(input int k);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    if (k == 0) supply_event_i <= 1'b1;
    else if (k == 1) sleep_event_i <= 1'b1;
    else fault_cond_i[k - 2] <= 1'b1;
    @(posedge clk_sys_i);
    supply_event_i <= 1'b0;
    sleep_event_i <= 1'b0;
    repeat (PLEN + 10) begin
      @(posedge clk_sys_i);
      sleep_event_i <= (n == 5);
      @(negedge clk_sys_i);
      if (stat_oe_n_o === 1'b0) n++;
    end
    chk("pulse length", 8'(PLEN), 8'(n));
  endtask

  task automatic t_errors();
    logic [7:0] v, v2;
    for (int i = 0; i < N_FAULTS; i++) begin
      pulse_chk(i + 2);
      @(posedge clk_sys_i);
      fault_cond_i[(i + 1) % N_FAULTS] <= 1'b1;
      reg_read(REG_STATUS_CTRL, v, v2);
      chk("first error", exp_reg(phase_i, 1'b0, 3'(i + 1)), v);
      chk("held error", exp_reg(phase_i, 1'b0, 3'(i + 1)), v2);
      @(posedge clk_sys_i);
      fault_cond_i <= 7'h00;
      reg_read(REG_STATUS_CTRL, v, v2);
      chk("read before clear", exp_reg(phase_i, 1'b0, 3'(i + 1)), v);
      chk("cleared error", exp_reg(phase_i, 1'b0, ERR_NONE), v2);
    end
  endtask

  task automatic t_level();
    pulse_chk(0);
    pulse_chk(1);
    @(posedge clk_sys_i);
    charging_i <= 1'b1;
    ind_enable_i <= 1'b1;
    cyc(4);
    chk("charging level", 8'h00, {7'h00, stat_oe_n_o});
    @(posedge clk_sys_i);
    ind_enable_i <= 1'b0;
    cyc(4);
    chk("level gated", 8'h01, {7'h00, stat_oe_n_o});
    @(posedge clk_sys_i);
    charging_i <= 1'b0;
    ind_enable_i <= 1'b1;
    cyc(4);
    chk("done released", 8'h01, {7'h00, stat_oe_n_o});
    chk("drive split", 8'h00, 8'(splits));
  endtask

  // Main sequence: reset held 16 cycles, filter settles, then scenarios
  initial begin
    repeat (16) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_sys_i);
    t_reset_phase();
    t_write();
    t_addr();
    t_hiz();
    t_errors();
    t_level();
    stop_test();
  end

  // Hang guard at 50k cycles, over twice the expected run
  initial begin
    #500000;
    num_errors++;
    $display("CHECK FAILED watchdog expected finish seen timeout");
    stop_test();
  end
endmodule // chs_host_link_test

// >>> testbench/chs_host_model.sv
// Two-wire bus controller model that plays the host against the target.
// Assumes open-drain lines whose pull-ups are resolved by the bench.
`timescale 1ns/1ps
module chs_host_model (
  // Clock
  input  wire logic clk_sys_i,
  // Resolved data line and host line drives
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  logic hi_long;

  // Idle bus: both lines released, clock stands still between frames
  initial begin
    scl_o     = 1'b1;
    sda_low_o = 1'b0;
    hi_long   = 1'b0;
  end

  // Low phase of eight clocks leaves room for the target's filtered turnaround;
  // high phase alternates four and five clocks so two bits span 250 ns
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // Start, or repeated start when the clock is low
  task automatic start();
    if (scl_o === 1'b0) begin
      sda_low_o <= 1'b0;
      tick(6);
      scl_o <= 1'b1;
      tick(4);
    end
    sda_low_o <= 1'b1;
    tick(4);
    scl_o <= 1'b0;
    tick(2);
  endtask

  // Stop: data rises while the clock is high, also after an abandoned frame
  task automatic stop();
    sda_low_o <= 1'b1;
    tick(6);
    scl_o <= 1'b1;
    tick(4);
    sda_low_o <= 1'b0;
    tick(4);
  endtask

  // One bit; data moves only while the clock is low
  task automatic bit_io(input logic v, output logic s);
    sda_low_o <= ~v;
    tick(6);
    scl_o <= 1'b1;
    tick(4 + int'(hi_long));
    hi_long = ~hi_long;
    s = sda_i;
    scl_o <= 1'b0;
    tick(2);
  endtask

  // Byte out MSB first, then sample the target's acknowledge
  task automatic write_byte(input logic [7:0] b, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, ack_n);
  endtask

  // Byte in MSB first; host acknowledges all but the last byte
  task automatic read_byte(input logic ack_it, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
    bit_io(~ack_it, s);
  endtask
endmodule // chs_host_model
